// ===== hdl/aspc_pkg.sv
// Shared constants for the audio slot port control block.
// Assumes a single 100 MHz system clock and an AHB-Lite register bus.
package aspc_pkg;

  // Register byte addresses
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CFG1 = 12'h0f4;
  localparam logic [11:0] ADDR_CFG2 = 12'h0f8;
  localparam logic [11:0] ADDR_DMA = 12'h100;
  localparam logic [11:0] ADDR_STAT = 12'h104;
  localparam logic [11:0] ADDR_LEVEL = 12'h140;

  // Mode and limit register field positions
  localparam int MODE_LSB = 29;
  localparam int LIMIT_LSB = 22;
  localparam int LIMIT_W = 7;
  localparam int WS_LINES = 5;
  localparam int CTRL_LSB0 = 18;
  localparam int SYNC_LSB0 = 16;
  localparam int WS_STEP = 4;

  // Clock register field positions
  localparam int CLKSRC1_LSB = 27;
  localparam int CLKSRC2_LSB = 22;
  localparam int INV1_BIT = 21;
  localparam int INV2_BIT = 20;
  localparam int OEN1_BIT = 19;
  localparam int OEN2_BIT = 18;
  localparam logic [31:0] CFG2_MASK = 32'hfffc0000;

  // Status register field positions
  localparam int STAT_RUN_LSB = 0;
  localparam int STAT_MODE_LSB = 4;
  localparam int STAT_CTRL_LSB = 8;

  // Reset values
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [6:0] LIMIT_RST = 7'h00;
  localparam logic [9:0] WS_RST = 10'h000;
  localparam logic [31:0] CFG2_RST = 32'h000c0000;
  localparam logic [31:0] LEVEL_RST = 32'h00000000;

  // Mode codes; all codes from MODE_LOCK up run both lists on port one's timing
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_ONE = 3'h1;
  localparam logic [2:0] MODE_TWO = 3'h2;
  localparam logic [2:0] MODE_LOCK = 3'h4;

  // Word-select line function and pulse shape codes
  localparam logic [1:0] CTRL_INPUT = 2'h0;
  localparam logic [1:0] CTRL_LIST1 = 2'h1;
  localparam logic [1:0] CTRL_LIST2 = 2'h2;
  localparam logic [1:0] CTRL_STATIC = 2'h3;
  localparam logic [1:0] SYNC_I2S = 2'h0;
  localparam logic [1:0] SYNC_SLOT = 2'h1;
  localparam logic [1:0] SYNC_PRE = 2'h2;
  localparam logic [1:0] SYNC_PULSE = 2'h3;

  // Bit clock source codes
  localparam logic [4:0] CLK_PIN_OWN = 5'h00;
  localparam logic [4:0] CLK_PIN_SWAP = 5'h01;

  typedef enum logic [2:0] {
    RUN_OFF = 3'b001,
    RUN_WAIT = 3'b010,
    RUN_ON = 3'b100
  } aspc_run_t;

  // Master clock divisor per source code; zero means no divider in use
  function automatic logic [8:0] aspc_div(input logic [4:0] code);
    case (code)
      5'h02: aspc_div = 9'h001;
      5'h03: aspc_div = 9'h002;
      5'h04: aspc_div = 9'h003;
      5'h05: aspc_div = 9'h004;
      5'h06: aspc_div = 9'h006;
      5'h07: aspc_div = 9'h008;
      5'h08: aspc_div = 9'h00c;
      5'h09: aspc_div = 9'h010;
      5'h0a: aspc_div = 9'h018;
      5'h0b: aspc_div = 9'h020;
      5'h0c: aspc_div = 9'h030;
      5'h0d: aspc_div = 9'h040;
      5'h0e: aspc_div = 9'h060;
      5'h0f: aspc_div = 9'h080;
      5'h10: aspc_div = 9'h0c0;
      5'h11: aspc_div = 9'h100;
      5'h12: aspc_div = 9'h180;
      default: aspc_div = 9'h000;
    endcase
  endfunction

  // Port zero runs in every mode but the off mode and port-two-only
  function automatic logic aspc_port_on(input logic [2:0] mode, input int port);
    if (port == 0) aspc_port_on = (mode != MODE_OFF) && (mode != MODE_TWO);
    else aspc_port_on = (mode != MODE_OFF) && (mode != MODE_ONE);
  endfunction

endpackage

// ===== hdl/aspc_bclk_div.sv
// Master audio clock divider for one audio port bit clock.
// Assumes aclkRise is a one-cycle pulse from an already synchronised master clock.
`timescale 1ns/1ps
module aspc_bclk_div #(
  parameter int CNT_W = 9
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Divider control
  input wire logic aclkRise,
  input wire logic [CNT_W-1:0] divisor,
  // Divided clock
  output logic tick,
  output logic level
);
  import aspc_pkg::*;

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic wrap;

  if (CNT_W < 9) begin : g_bad_width
    $error("aspc_bclk_div: CNT_W too small for divide by 384");
  end

  // Wrap after divisor master edges; a zero divisor parks the counter
  assign wrap = aclkRise && (divisor != '0) && (cnt >= divisor - 1'b1);
  assign next_cnt = wrap ? '0 : (cnt + 1'b1);

  // Counter and tick; odd divisors above one give a high phase one edge shorter
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt <= '0;
      tick <= 1'b0;
      level <= 1'b0;
    end else begin
      tick <= wrap;
      if (aclkRise && divisor != '0) begin
        cnt <= next_cnt;
        level <= (next_cnt < (divisor >> 1)) || (divisor == 9'h001);
      end
    end
  end

  a_div_wrap: assert property (@(posedge clk) disable iff (!rstn)
    (aclkRise && divisor != '0 && cnt == divisor - 1'b1) |=> tick)
    else $error("divider missed its wrap tick");

endmodule // aspc_bclk_div

// ===== hdl/aspc_audio_ctrl.sv
// Audio slot port control: level monitor, word-select lines, bit clock
// selection and buffered mode switching, with an AHB-Lite register slave.
// Assumes samples, DMA protection hits and the bus are on clk; pins are not.
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
module aspc_audio_ctrl #(
  parameter int SLOTS = 16,
  parameter int SLOT_BITS = 16,
  parameter int DMA_CH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Sample stream for level monitoring
  input wire logic sampleValid,
  input wire logic [4:0] sampleSlot,
  input wire logic [7:0] sampleMsb,
  // DMA engine side
  input wire logic [1:0] protHit,
  output logic [DMA_CH-1:0] dmaEnable,
  output logic [DMA_CH-1:0] dmaFlush,
  // Pins: master clock, bit clocks, word-select lines
  input wire logic aclkPin,
  input wire logic [1:0] bclkPinIn,
  output logic [1:0] bclkPinOut,
  output logic [1:0] bclkPinOe_n,
  input wire logic [1:0] wsPinIn,
  output logic [aspc_pkg::WS_LINES-1:0] wsPinOut,
  output logic [aspc_pkg::WS_LINES-1:0] wsPinOe_n
);
  import aspc_pkg::*;

  localparam int BW = $clog2(SLOT_BITS);
  localparam logic [BW-1:0] LAST_BIT = BW'(SLOT_BITS - 1);
  localparam logic [4:0] LAST_SLOT = 5'(SLOTS - 1);

  if (SLOTS < WS_LINES || SLOTS > 16 || SLOT_BITS < 3 || DMA_CH < 1 || DMA_CH > 32)
  begin : g_bad_param
    $error("aspc_audio_ctrl: parameter out of range");
  end

  // Bus and register state
  logic take, wrPend, rdPend, addrOk;
  logic [11:0] addrQ;
  logic wrCfg1, wrCfg2, wrDma, readClr;
  logic [2:0] shMode, actMode;
  logic [9:0] shCtrl, actCtrl, syncCfg, next_ctrl, next_sync;
  logic [6:0] peakLimit;
  logic [31:0] cfg2, level, violBits, rdMux;
  logic [7:0] sampleMag;
  logic lock;
  // Pin synchronisers and edges
  logic aclkS1, aclkS2, aclkS3, aclkRise;
  logic [1:0] bclkS1, bclkS2, bclkS3, pinEdge, wsS1, wsS2, wsS3, wsRise;
  // Per-port and per-list timing
  logic [1:0] portTick, divTick, divLevel, inv, tickSel, extSel, ptrRst;
  logic [4:0] clkSrc [2];
  logic [BW-1:0] bitCnt [2];
  logic [4:0] slotCnt [2];
  aspc_run_t runState [2];

  // Address phase is taken only for whole-word transfers
  assign take = hsel && htrans[1] && hready && (hsize == 3'h2);
  assign wrCfg1 = wrPend && addrOk && (addrQ == ADDR_CFG1);
  assign wrCfg2 = wrPend && addrOk && (addrQ == ADDR_CFG2);
  assign wrDma = wrPend && addrOk && (addrQ == ADDR_DMA);
  assign readClr = rdPend && addrOk && (addrQ == ADDR_LEVEL);
  // Reads take one wait state so read data come from a flop with fresh contents
  assign hreadyout = !rdPend;
  assign hresp = 1'b0;

  // Address phase capture
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wrPend <= 1'b0;
      rdPend <= 1'b0;
      addrOk <= 1'b0;
      addrQ <= 12'h000;
    end else begin
      wrPend <= take && hwrite;
      rdPend <= take && !hwrite;
      if (take) begin
        addrQ <= haddr[ADDR_W-1:0];
        addrOk <= (haddr[31:ADDR_W] == '0);
      end
    end
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rdMux = 32'h00000000;
    unique case (addrQ)
      ADDR_CFG1: begin
        rdMux[MODE_LSB +: 3] = shMode;
        rdMux[LIMIT_LSB +: LIMIT_W] = peakLimit;
        for (int x = 0; x < WS_LINES; x++) begin
          rdMux[CTRL_LSB0 - WS_STEP * x +: 2] = shCtrl[2 * x +: 2];
          rdMux[SYNC_LSB0 - WS_STEP * x +: 2] = syncCfg[2 * x +: 2];
        end
      end
      ADDR_CFG2: rdMux = cfg2;
      ADDR_DMA: rdMux[DMA_CH-1:0] = dmaEnable;
      ADDR_STAT: begin
        rdMux[STAT_RUN_LSB] = (runState[0] == RUN_ON);
        rdMux[STAT_RUN_LSB + 1] = (runState[1] == RUN_ON);
        rdMux[STAT_MODE_LSB +: 3] = actMode;
        rdMux[STAT_CTRL_LSB +: 10] = actCtrl;
      end
      ADDR_LEVEL: rdMux = level;
      default: rdMux = 32'h00000000;
    endcase
  end

  // Read data register
  always_ff @(posedge clk) begin
    if (!rstn) hrdata <= 32'h00000000;
    else if (rdPend) hrdata <= addrOk ? rdMux : 32'h00000000;
  end

  // Unpack line function and shape fields from the write data
  always_comb begin
    next_ctrl = WS_RST;
    next_sync = WS_RST;
    for (int x = 0; x < WS_LINES; x++) begin
      next_ctrl[2 * x +: 2] = hwdata[CTRL_LSB0 - WS_STEP * x +: 2];
      next_sync[2 * x +: 2] = hwdata[SYNC_LSB0 - WS_STEP * x +: 2];
    end
  end

  // Shadowed mode and line functions; live values change only at safe points
  always_ff @(posedge clk) begin
    if (!rstn) begin
      shMode <= MODE_RST;
      shCtrl <= WS_RST;
      actMode <= MODE_RST;
      actCtrl <= WS_RST;
      peakLimit <= LIMIT_RST;
      syncCfg <= WS_RST;
    end else begin
      if (wrCfg1) begin
        shMode <= hwdata[MODE_LSB +: 3];
        shCtrl <= next_ctrl;
        peakLimit <= hwdata[LIMIT_LSB +: LIMIT_W];
        syncCfg <= next_sync;
      end
      if (wrCfg1 && actMode == MODE_OFF) begin
        actMode <= hwdata[MODE_LSB +: 3];
        actCtrl <= next_ctrl;
      end else if (|protHit) begin
        actMode <= shMode;
        actCtrl <= shCtrl;
      end
    end
  end

  // Clock configuration; bit clock pins drive while their enable bit is low
  always_ff @(posedge clk) begin
    if (!rstn) cfg2 <= CFG2_RST;
    else if (wrCfg2) cfg2 <= hwdata & CFG2_MASK;
  end
  assign bclkPinOe_n = {cfg2[OEN2_BIT], cfg2[OEN1_BIT]};
  assign inv = {cfg2[INV2_BIT], cfg2[INV1_BIT]};
  assign clkSrc[0] = cfg2[CLKSRC1_LSB +: 5];
  assign clkSrc[1] = cfg2[CLKSRC2_LSB +: 5];

  // DMA enables; a falling enable flushes the FIFO and rewinds the pointers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dmaEnable <= '0;
      dmaFlush <= '0;
    end else begin
      dmaFlush <= wrDma ? (dmaEnable & ~hwdata[DMA_CH-1:0]) : '0;
      if (wrDma) dmaEnable <= hwdata[DMA_CH-1:0];
    end
  end

  // Level check on the sample's top byte; magnitude 128 always exceeds 127
  assign sampleMag = sampleMsb[7] ? (8'h00 - sampleMsb) : sampleMsb;
  assign violBits = (sampleValid && sampleMag > {1'b0, peakLimit}) ?
                    (32'h00000001 << sampleSlot) : 32'h00000000;

  // Violation word: cleared by its read, but a same-cycle hit survives
  always_ff @(posedge clk) begin
    if (!rstn) level <= LEVEL_RST;
    else level <= (readClr ? LEVEL_RST : level) | violBits;
  end

  // Two-flop synchronisers; edge detectors read only the second stage onward
  always_ff @(posedge clk) begin
    if (!rstn) begin
      {aclkS1, aclkS2, aclkS3} <= 3'h0;
      {bclkS1, bclkS2, bclkS3} <= 6'h00;
      {wsS1, wsS2, wsS3} <= 6'h00;
    end else begin
      {aclkS3, aclkS2, aclkS1} <= {aclkS2, aclkS1, aclkPin};
      {bclkS3, bclkS2, bclkS1} <= {bclkS2, bclkS1, bclkPinIn};
      {wsS3, wsS2, wsS1} <= {wsS2, wsS1, wsPinIn};
    end
  end
  assign aclkRise = aclkS2 && !aclkS3;
  // Inverted pins count their falling edge as the active edge
  assign pinEdge = (bclkS2 & ~bclkS3 & ~inv) | (~bclkS2 & bclkS3 & inv);
  // Pointer reset inputs only act while their line is in input function
  assign wsRise[0] = wsS2[0] && !wsS3[0] && (actCtrl[1:0] == CTRL_INPUT);
  assign wsRise[1] = wsS2[1] && !wsS3[1] && (actCtrl[9:8] == CTRL_INPUT);

  // Lock modes run list two on port one's clock and pointer reset
  assign lock = (actMode >= MODE_LOCK);
  assign tickSel = {lock ? portTick[0] : portTick[1], portTick[0]};
  assign extSel = {lock ? wsRise[0] : wsRise[1], wsRise[0]};

  // Per-port bit clock source, divider, pin output and run state
  for (genvar p = 0; p < 2; p++) begin : g_port
    aspc_bclk_div #(.CNT_W(9)) u_div (
      .clk(clk),
      .rstn(rstn),
      .aclkRise(aclkRise),
      .divisor(aspc_div(clkSrc[p])),
      .tick(divTick[p]),
      .level(divLevel[p])
    );

    // Own pin, swapped pin, or divided master clock; reserved codes stall
    assign portTick[p] = (clkSrc[p] == CLK_PIN_OWN) ? pinEdge[p] :
                         (clkSrc[p] == CLK_PIN_SWAP) ? pinEdge[1 - p] : divTick[p];

    // Driven bit clock follows the divider with the programmed polarity
    always_ff @(posedge clk) begin
      if (!rstn) bclkPinOut[p] <= 1'b0;
      else bclkPinOut[p] <= divLevel[p] ^ inv[p];
    end

    // An enabled port waits for a pointer reset so it never joins mid-frame
    always_ff @(posedge clk) begin
      if (!rstn) runState[p] <= RUN_OFF;
      else begin
        unique case (runState[p])
          RUN_OFF: if (aspc_port_on(actMode, p)) runState[p] <= RUN_WAIT;
          RUN_WAIT: begin
            if (!aspc_port_on(actMode, p)) runState[p] <= RUN_OFF;
            else if (ptrRst[p]) runState[p] <= RUN_ON;
          end
          RUN_ON: if (!aspc_port_on(actMode, p)) runState[p] <= RUN_OFF;
          default: runState[p] <= RUN_OFF;
        endcase
      end
    end
  end

  // Slot-list pointers: bit within slot and slot within frame
  for (genvar l = 0; l < 2; l++) begin : g_list
    assign ptrRst[l] = extSel[l] ||
                       (tickSel[l] && bitCnt[l] == LAST_BIT && slotCnt[l] == LAST_SLOT);
    always_ff @(posedge clk) begin
      if (!rstn || extSel[l]) begin
        bitCnt[l] <= '0;
        slotCnt[l] <= 5'h00;
      end else if (tickSel[l]) begin
        if (bitCnt[l] == LAST_BIT) begin
          bitCnt[l] <= '0;
          slotCnt[l] <= (slotCnt[l] == LAST_SLOT) ? 5'h00 : slotCnt[l] + 5'h01;
        end else begin
          bitCnt[l] <= bitCnt[l] + 1'b1;
        end
      end
    end
  end

  // Word-select lines; line x marks slot x of its timing list
  for (genvar x = 0; x < WS_LINES; x++) begin : g_ws
    logic [1:0] ctrl, sync;
    logic lst, inSlot, inPrev, lastB, pulse;
    assign ctrl = actCtrl[2 * x +: 2];
    assign sync = syncCfg[2 * x +: 2];
    assign lst = (ctrl == CTRL_LIST2);
    assign inSlot = (slotCnt[lst] == 5'(x));
    assign inPrev = (slotCnt[lst] == ((x == 0) ? LAST_SLOT : 5'(x - 1)));
    assign lastB = (bitCnt[lst] == LAST_BIT);

    // Pulse shape against the bit position of the timing list
    always_comb begin
      unique case (sync)
        SYNC_I2S: pulse = (inPrev && lastB) || (inSlot && !lastB);
        SYNC_SLOT: pulse = inSlot;
        SYNC_PRE: pulse = inPrev && lastB;
        SYNC_PULSE: pulse = inSlot && (bitCnt[lst] == '0 ||
                            (x == 0 && bitCnt[lst] == BW'(1)));
        default: pulse = 1'b0;
      endcase
    end

    // Input function floats the line; static function holds it low
    always_ff @(posedge clk) begin
      if (!rstn) begin
        wsPinOut[x] <= 1'b0;
        wsPinOe_n[x] <= 1'b1;
      end else begin
        wsPinOe_n[x] <= (ctrl == CTRL_INPUT);
        wsPinOut[x] <= (ctrl == CTRL_LIST1 || ctrl == CTRL_LIST2) &&
                       (runState[lst] == RUN_ON) && pulse;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_peak_over: assert property (
    (sampleValid && sampleMag > {1'b0, peakLimit}) |=> level[$past(sampleSlot)])
    else $error("violation above limit not flagged");
  a_peak_within: assert property (
    (sampleValid && sampleMag <= {1'b0, peakLimit} && readClr) |=> level == 32'h0)
    else $error("sample within limit flagged");
  a_level_clear: assert property (
    (readClr && !sampleValid) |=> (level == 32'h0) ##1 (hrdata == $past(level, 2)))
    else $error("violation word not cleared by read");
  a_set_wins: assert property (
    (readClr && violBits != 32'h0) |=> level == $past(violBits))
    else $error("violation lost at clearing read");
  a_ws_static: assert property (
    (actCtrl[3:2] == CTRL_STATIC) |=> (!wsPinOut[1] && !wsPinOe_n[1]))
    else $error("static line not driven low");
  a_ws_float: assert property (
    (actCtrl[5:4] == CTRL_INPUT) |=> (wsPinOe_n[2] && !wsPinOut[2]))
    else $error("input-function line driven");
  a_shadow_hold: assert property (
    (wrCfg1 && actMode != MODE_OFF && protHit == 2'h0) |=> $stable(actMode))
    else $error("mode changed before protection hit");
  a_load_off: assert property (
    (wrCfg1 && actMode == MODE_OFF) |=> actMode == $past(hwdata[MODE_LSB +: 3]))
    else $error("mode not loaded at once while off");
  a_run_wait: assert property (
    (runState[0] == RUN_WAIT && !ptrRst[0]) |=> runState[0] != RUN_ON)
    else $error("port started away from pointer reset");
  a_dma_flush: assert property (
    (wrDma && |(dmaEnable & ~hwdata[DMA_CH-1:0])) |=>
    (dmaFlush == $past(dmaEnable & ~hwdata[DMA_CH-1:0])) ##1 (dmaFlush == '0 || $past(wrDma)))
    else $error("disabled channel not flushed");
  a_bclk_oe: assert property (
    wrCfg2 |=> bclkPinOe_n[0] == $past(hwdata[OEN1_BIT]))
    else $error("bit clock enable not applied");

  c_violation_read: cover property (readClr && level != 32'h0);
  c_port_running: cover property (runState[0] == RUN_WAIT ##1 runState[0] == RUN_ON);
  c_shadow_load: cover property (shMode != actMode && |protHit ##1 shMode == actMode);
  c_dma_flush: cover property (|dmaFlush);

endmodule // aspc_audio_ctrl

// ===== tb/aspc_codec_model.sv
// Codec-side model: master audio clock, bit clocks and word-select inputs.
// Assumes the bench raises run only while a framed stream should flow.
`timescale 1ns/1ps
module aspc_codec_model #(
  parameter int SLOT_BITS = 4
) (
  // Frame control
  input wire logic run,
  // Pins toward the block
  output logic aclk,
  output logic [1:0] bclk,
  output logic [1:0] ws
);
  int bitCnt = 0;
  // Master clock runs free, well below half the system clock
  initial aclk = 1'b0;
  always #37 aclk = ~aclk;
  // Bit clocks toggle only within frames and stand low between them
  initial bclk = 2'b00;
  always #100 bclk = run ? ~bclk : 2'b00;
  // Frame sync flips once per slot, so its rising edge marks every second slot
  initial ws = 2'b00;
  always @(negedge bclk[0]) begin
    bitCnt = (bitCnt + 1) % SLOT_BITS;
    if (bitCnt == 0) ws = ~ws;
  end
endmodule // aspc_codec_model

// ===== tb/aspc_audio_ctrl_tb.sv
// Self-checking bench for the audio slot port control block.
// Assumes one 100 MHz clock; the codec model supplies all pin clocks.
`timescale 1ns/1ps
module aspc_audio_ctrl_tb;
  import aspc_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b1;
  logic hwrite = 1'b0;
  logic sampleValid = 1'b0;
  logic run = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [1:0] htrans = 2'h0;
  logic [1:0] protHit = 2'h0;
  logic [4:0] sampleSlot = 5'h0;
  logic [7:0] sampleMsb = 8'h0;
  wire logic hreadyout, hresp, aclk;
  wire logic [31:0] hrdata;
  wire logic [3:0] dmaEnable, dmaFlush;
  wire logic [1:0] bclk, ws, bclkOut, bclkOe_n;
  wire logic [4:0] wsOut, wsOe_n;
  int nErrors = 0;
  int samplesChecked = 0;
  int cycles = 0;

  // Clock source
  always #5 clk = ~clk;

  aspc_audio_ctrl #(.SLOTS(5), .SLOT_BITS(4), .DMA_CH(4)) u_dut (
    .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sampleValid(sampleValid), .sampleSlot(sampleSlot), .sampleMsb(sampleMsb),
    .protHit(protHit), .dmaEnable(dmaEnable), .dmaFlush(dmaFlush),
    .aclkPin(aclk), .bclkPinIn(bclk), .bclkPinOut(bclkOut), .bclkPinOe_n(bclkOe_n),
    .wsPinIn(ws), .wsPinOut(wsOut), .wsPinOe_n(wsOe_n));

  aspc_codec_model #(.SLOT_BITS(4)) u_codec (.run(run), .aclk(aclk), .bclk(bclk), .ws(ws));

  // Hang guard: far above the thousand or so cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      nErrors++;
      endOfTest();
    end
  end

  task automatic endOfTest();
    $display("checks %0d mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samplesChecked++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask

  // One single-word transfer; the data phase waits for the slave's ready
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "hresp");
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask

  task automatic send(input logic [4:0] slot, input logic [7:0] msb);
    @(posedge clk);
    sampleValid <= 1'b1;
    sampleSlot <= slot;
    sampleMsb <= msb;
  endtask

  task automatic tReset();
    int n = 0;
    logic prev = 1'b0;
    chk({27'h0, wsOe_n}, 32'h1f, "ws float");
    chk({30'h0, bclkOe_n}, 32'h3, "bclk in");
    rdchk(ADDR_CFG2, CFG2_RST, "cfg2 reset");
    rdchk(ADDR_LEVEL, 32'h0, "level reset");
    rdchk(12'h200, 32'h0, "unmapped");
    bus(1'b1, ADDR_CFG2, 32'h18040000);
    @(posedge clk);
    chk({30'h0, bclkOe_n}, 32'h2, "pin one drives");
    // Master clock over two: about one output edge per master period
    repeat (300) begin
      @(posedge clk);
      if (bclkOut[0] !== prev) n++;
      prev = bclkOut[0];
    end
    chk({31'h0, n > 30 && n < 50}, 32'h1, "div2 edges");
    $display("reset and clock test done");
  endtask

  task automatic tLines();
    // Line enables are registered from the live function, so they show two edges on
    bus(1'b1, ADDR_CFG1, 32'h000c4000);
    repeat (2) @(posedge clk);
    chk({27'h0, wsOe_n}, 32'h1c, "lines driven");
    chk({31'h0, wsOut[0]}, 32'h0, "static low");
    rdchk(ADDR_STAT, 32'h700, "live functions");
    bus(1'b1, ADDR_CFG1, 32'h0);
    repeat (2) @(posedge clk);
    chk({27'h0, wsOe_n}, 32'h1f, "lines float");
    $display("line function test done");
  endtask

  task automatic tLevel();
    bus(1'b1, ADDR_CFG1, 32'h19000000);
    send(5'd3, 8'h90);
    send(5'd5, 8'h64);
    send(5'd7, 8'h9c);
    send(5'd9, 8'h65);
    send(5'd31, 8'h80);
    @(posedge clk);
    sampleValid <= 1'b0;
    rdchk(ADDR_LEVEL, 32'h80000208, "violations");
    rdchk(ADDR_LEVEL, 32'h0, "cleared");
    bus(1'b1, ADDR_CFG1, 32'h1fc00000);
    send(5'd1, 8'h81);
    send(5'd2, 8'h80);
    @(posedge clk);
    sampleValid <= 1'b0;
    rdchk(ADDR_LEVEL, 32'h4, "limit 127");
    $display("level test done");
  endtask

  task automatic tDma();
    int n = 0;
    bus(1'b1, ADDR_DMA, 32'hf);
    rdchk(ADDR_DMA, 32'hf, "dma on");
    bus(1'b1, ADDR_DMA, 32'h5);
    // Flush pulse is launched at the write edge, so the first look is just after it
    repeat (4) begin
      #1;
      if (dmaFlush === 4'ha) n++;
      @(posedge clk);
    end
    chk(n, 32'h1, "flush pulse");
    chk({28'h0, dmaEnable}, 32'h5, "dma enables");
    $display("dma test done");
  endtask

  task automatic tMode();
    int n = 0;
    // Own-pin bit clocks stand still until the codec runs, so no pointer reset comes early
    bus(1'b1, ADDR_CFG2, CFG2_RST);
    bus(1'b1, ADDR_CFG1, 32'h20000000);
    rdchk(ADDR_STAT, 32'h10, "mode loads at once");
    // Line 1 timed by list one with the whole-slot shape
    bus(1'b1, ADDR_CFG1, 32'h60005000);
    rdchk(ADDR_STAT, 32'h10, "mode held");
    rdchk(ADDR_CFG1, 32'h60005000, "shadow");
    @(posedge clk);
    protHit <= 2'h1;
    @(posedge clk);
    protHit <= 2'h0;
    rdchk(ADDR_STAT, 32'h430, "mode switched");
    run <= 1'b1;
    // Codec frames are two slots long, so slot 1 fills about half of each frame
    repeat (500) begin
      @(posedge clk);
      if (wsOut[1] === 1'b1) n++;
    end
    rdchk(ADDR_STAT, 32'h433, "ports started");
    run <= 1'b0;
    chk({31'h0, n > 120 && n < 280}, 32'h1, "slot-wide select");
    $display("mode test done");
  endtask

  // Main sequence: reset for three cycles, then the tests in turn
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    tReset();
    tLines();
    tLevel();
    tDma();
    tMode();
    endOfTest();
  end
endmodule // aspc_audio_ctrl_tb
